// ==== pwm_pin_partner.sv ====
// pin-side partner of the reload timer: capture sources and pwm pin loads
`timescale 1ns/10ps

module pwm_pin_partner (
    // capture requests from the bench
    input  wire logic [1:0] cap_req,
    // external clock request from the bench
    input  wire logic       ext_req,
    // pins toward the timer
    output logic      [1:0] cap_pin,
    output logic            ext_clk_pin,
    input  wire logic [3:0] pwm_out,
    input  wire logic [3:0] pwm_oe,
    // pin levels seen on the board
    output logic      [3:0] pin_level
);
    // bench changes requests just after an edge, so the pin is never raced
    assign cap_pin = cap_req;
    // external clock follows the bench; its edges stay several clocks apart
    assign ext_clk_pin = ext_req;
    // an undriven pwm pin falls to its pull-down
    assign pin_level = pwm_oe & pwm_out;
endmodule : pwm_pin_partner

// ==== pwm_reload_timer.sv ====
// 8-bit auto-reload timer with four pwm outputs and two input captures, apb slave
`timescale 1ns/10ps
`include "pwm_reload_timer_regs.svh"

module pwm_reload_timer #(
    parameter int PWM_CH = 4,
    parameter int CAP_CH = 2
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // pins
    input  wire logic        EXT_CLK_IN,
    input  wire logic [1:0]  CAP_IN,
    output logic      [3:0]  PWM_OUT,
    output logic      [3:0]  PWM_OE,
    // interrupt requests
    output logic             IRQ_OVF,
    output logic             IRQ_CAP
);

    // mask of prescaler bits that must all be set for a counter tick
    function automatic pwm_reload_timer_pkg::presc_t presc_mask(
        input pwm_reload_timer_pkg::clk_sel_t sel);
        pwm_reload_timer_pkg::presc_t m;
        m = '0;
        for (int i = 0; i < `PRESC_W; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : presc_mask

    // register index range check
    function automatic logic idx_in(input pwm_reload_timer_pkg::reg_idx_t idx,
                                    input pwm_reload_timer_pkg::reg_idx_t lo,
                                    input pwm_reload_timer_pkg::reg_idx_t hi);
        return (idx >= lo) && (idx <= hi);
    endfunction : idx_in

    // reset release
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // pin synchronisers; the edge stage reads only the second flop
    logic [1:0] ext_sync_reg;
    logic       ext_prev_reg;
    logic [1:0] cap_s1_reg;
    logic [1:0] cap_s2_reg;
    logic [1:0] cap_prev_reg;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
            cap_s1_reg   <= 2'h0;
            cap_s2_reg   <= 2'h0;
            cap_prev_reg <= 2'h0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], EXT_CLK_IN};
            ext_prev_reg <= ext_sync_reg[1];
            cap_s1_reg   <= CAP_IN;
            cap_s2_reg   <= cap_s1_reg;
            cap_prev_reg <= cap_s2_reg;
        end
    end

    // registers
    pwm_reload_timer_pkg::byte_t    duty_reg [PWM_CH];
    pwm_reload_timer_pkg::byte_t    cmp_reg  [PWM_CH];
    pwm_reload_timer_pkg::byte_t    cap_reg  [CAP_CH];
    pwm_reload_timer_pkg::byte_t    cnt_reg;
    pwm_reload_timer_pkg::byte_t    reload_reg;
    pwm_reload_timer_pkg::presc_t   presc_reg;
    pwm_reload_timer_pkg::clk_sel_t cc_reg;
    logic [3:0]                     oe_reg;
    logic [3:0]                     op_reg;
    logic                           ext_sel_reg;
    logic                           run_reg;
    logic                           oie_reg;
    logic                           ovf_reg;
    logic [1:0]                     cap_sel_reg;
    logic [1:0]                     cap_ie_reg;
    logic [1:0]                     cap_flag_reg;
    pwm_reload_timer_pkg::byte_t    rd_data_reg;
    logic [3:0]                     pwm_out_reg;

    // apb decode
    pwm_reload_timer_pkg::reg_idx_t idx;
    logic                           mapped;
    logic                           setup_ph;
    logic                           access_ph;
    logic                           wr_en;
    logic                           rd_done;
    logic                           wr_duty;
    logic                           wr_pwm_ctrl;
    logic                           wr_csr;
    logic                           wr_cnt;
    logic                           wr_reload;
    logic                           wr_cap_csr;
    logic                           force_load;
    logic [1:0]                     duty_ch;
    pwm_reload_timer_pkg::byte_t    wbyte;
    pwm_reload_timer_pkg::byte_t    rd_mux;

    assign idx       = PADDR[11:2];
    assign mapped    = (PADDR[1:0] == 2'h0) && idx_in(idx, `IDX_DUTY_CH3, `IDX_CAP_CH2);
    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign wr_en     = access_ph && PWRITE && mapped && PSTRB[0];
    assign rd_done   = access_ph && !PWRITE && mapped;
    assign wbyte     = PWDATA[7:0];
    assign wr_duty     = wr_en && idx_in(idx, `IDX_DUTY_CH3, `IDX_DUTY_CH0);
    assign wr_pwm_ctrl = wr_en && (idx == `IDX_PWM_CTRL);
    assign wr_csr      = wr_en && (idx == `IDX_TIMER_CSR);
    assign wr_cnt      = wr_en && (idx == `IDX_COUNTER);
    assign wr_reload   = wr_en && (idx == `IDX_RELOAD);
    assign wr_cap_csr  = wr_en && (idx == `IDX_CAP_CSR);
    assign force_load  = wr_csr && wbyte[`CSR_FORCE_BIT];
    assign duty_ch     = 2'(`IDX_DUTY_CH0 - idx);

    always_comb begin
        rd_mux = `REG_RESET;
        case (idx)
            `IDX_DUTY_CH3:  rd_mux = duty_reg[3];
            `IDX_DUTY_CH2:  rd_mux = duty_reg[2];
            `IDX_DUTY_CH1:  rd_mux = duty_reg[1];
            `IDX_DUTY_CH0:  rd_mux = duty_reg[0];
            `IDX_PWM_CTRL:  rd_mux = {oe_reg, op_reg};
            `IDX_TIMER_CSR: rd_mux = {ext_sel_reg, cc_reg, run_reg, 1'b0, oie_reg, ovf_reg};
            `IDX_COUNTER:   rd_mux = cnt_reg;
            `IDX_RELOAD:    rd_mux = reload_reg;
            `IDX_CAP_CSR:   rd_mux = {2'h0, cap_sel_reg, cap_ie_reg, cap_flag_reg};
            `IDX_CAP_CH1:   rd_mux = cap_reg[0];
            `IDX_CAP_CH2:   rd_mux = cap_reg[1];
            default:        rd_mux = `REG_RESET;
        endcase
    end

    // read data is caught in setup; flags are cleared only if that snapshot saw them
    logic ovf_rd_clr;
    logic [1:0] cap_rd_clr;
    logic [1:0] snap_flag_reg;

    assign ovf_rd_clr    = rd_done && (idx == `IDX_TIMER_CSR) && rd_data_reg[`CSR_OVF_BIT];
    assign cap_rd_clr[0] = rd_done && (idx == `IDX_CAP_CH1) && snap_flag_reg[0];
    assign cap_rd_clr[1] = rd_done && (idx == `IDX_CAP_CH2) && snap_flag_reg[1];

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg   <= `REG_RESET;
            snap_flag_reg <= 2'h0;
        end else if (setup_ph) begin
            rd_data_reg   <= rd_mux;
            snap_flag_reg <= cap_flag_reg;
        end
    end

    assign PRDATA  = {24'h0, rd_data_reg};
    assign PREADY  = 1'b1;
    assign PSLVERR = access_ph && !mapped;

    // prescaler and counter tick
    logic in_tick;
    logic cnt_tick;
    logic ovf_evt;

    assign in_tick  = run_reg && (ext_sel_reg ? (ext_sync_reg[1] && !ext_prev_reg) : 1'b1);
    assign cnt_tick = in_tick && ((presc_reg & presc_mask(cc_reg)) == presc_mask(cc_reg));
    assign ovf_evt  = cnt_tick && (cnt_reg == `COUNT_MAX) && !wr_cnt && !force_load;

    // control registers clear to zero
    // write ignored bits hold
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            oe_reg      <= 4'h0;
            op_reg      <= 4'h0;
            ext_sel_reg <= 1'b0;
            cc_reg      <= 3'h0;
            run_reg     <= 1'b0;
            oie_reg     <= 1'b0;
            reload_reg  <= `REG_RESET;
            cap_sel_reg <= 2'h0;
            cap_ie_reg  <= 2'h0;
        end else begin
            if (wr_pwm_ctrl) begin
                oe_reg <= wbyte[`PWM_OE_LSB +: 4];
                op_reg <= wbyte[`PWM_OP_LSB +: 4];
            end
            if (wr_csr) begin
                ext_sel_reg <= wbyte[`CSR_EXT_CLK_BIT];
                cc_reg      <= wbyte[`CSR_CC_MSB:`CSR_CC_LSB];
                run_reg     <= wbyte[`CSR_RUN_BIT];
                oie_reg     <= wbyte[`CSR_OIE_BIT];
            end
            if (wr_reload) begin
                reload_reg <= wbyte;
            end
            if (wr_cap_csr) begin
                cap_sel_reg <= wbyte[`CAP_SEL_LSB +: 2];
                cap_ie_reg  <= wbyte[`CAP_IE_LSB +: 2];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PWM_CH; i++) begin
                duty_ref_clear: duty_reg[i] <= `REG_RESET;
            end
        end else if (wr_duty) begin
            duty_reg[duty_ch] <= wbyte;
        end
    end

    // counter: software load beats a tick, a forced reload beats both
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= `REG_RESET;
            presc_reg <= '0;
        end else if (force_load) begin
            cnt_reg   <= reload_reg;
            presc_reg <= '0;
        end else if (wr_cnt) begin
            cnt_reg   <= wbyte;
            presc_reg <= '0;
        end else begin
            if (in_tick) begin
                presc_reg <= presc_reg + 7'h01;
            end
            if (ovf_evt) begin
                cnt_reg <= reload_reg;
            end else if (cnt_tick) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    // compare values copied at overflow only
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PWM_CH; i++) begin
                cmp_reg[i] <= `REG_RESET;
            end
        end else if (ovf_evt) begin
            for (int i = 0; i < PWM_CH; i++) begin
                cmp_reg[i] <= duty_reg[i];
            end
        end
    end

    // overflow flag, set beats read clear
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= ovf_evt || (ovf_reg && !ovf_rd_clr);
        end
    end

    // capture: edge selected per channel, blocked while its flag stands
    logic [1:0] cap_edge;
    logic [1:0] cap_take;

    assign cap_edge = (cap_sel_reg & cap_s2_reg & ~cap_prev_reg)
                    | (~cap_sel_reg & ~cap_s2_reg & cap_prev_reg);
    assign cap_take = cap_edge & ~cap_flag_reg;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cap_flag_reg <= 2'h0;
            for (int i = 0; i < CAP_CH; i++) begin
                cap_reg[i] <= `REG_RESET;
            end
        end else begin
            cap_flag_reg <= cap_take | (cap_flag_reg & ~cap_rd_clr);
            for (int i = 0; i < CAP_CH; i++) begin
                if (cap_take[i]) begin
                    cap_reg[i] <= cnt_reg;
                end
            end
        end
    end

    assign IRQ_CAP = |(cap_flag_reg & cap_ie_reg);
    assign IRQ_OVF = ovf_reg && oie_reg;

    // reload zero gives 256-count period
    // a compare below the reload value never reaches the starting level
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out_reg <= 4'h0;
        end else begin
            for (int i = 0; i < PWM_CH; i++) begin
                pwm_out_reg[i] <= oe_reg[i] && ((cnt_reg <= cmp_reg[i]) ^ op_reg[i]);
            end
        end
    end

    assign PWM_OUT = pwm_out_reg;
    assign PWM_OE  = oe_reg;

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    sequence s_overflow;
        ovf_evt;
    endsequence

    sequence s_cnt_write;
        wr_cnt && !force_load;
    endsequence

    property p_cnt_load;
        s_cnt_write |=> (cnt_reg == $past(wbyte));
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("counter write not loaded");

    property p_reload;
        s_overflow |=> (cnt_reg == $past(reload_reg)) ##1 (cnt_reg == $past(cnt_reg) ||
            cnt_reg == $past(cnt_reg) + 8'h01 || $past(wr_cnt) || $past(force_load));
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload");

    property p_start_level;
        s_overflow ##1 (oe_reg[0] && !wr_pwm_ctrl && (cnt_reg <= cmp_reg[0]))
            |=> PWM_OUT[0] == !op_reg[0];
    endproperty
    a_start_level: assert property (p_start_level) else $error("bad start level");

    property p_disabled;
        !oe_reg[1] |=> !PWM_OUT[1];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled output active");

    property p_pol_flip;
        ($changed(op_reg[2]) && $stable(oe_reg[2]) && oe_reg[2] && $stable(cnt_reg)
            && $stable(cmp_reg[2])) |=> PWM_OUT[2] != $past(PWM_OUT[2]);
    endproperty
    a_pol_flip: assert property (p_pol_flip) else $error("polarity flip late");

    property p_cmp_copy;
        s_overflow |=> (cmp_reg[3] == $past(duty_reg[3])) && (cmp_reg[0] == $past(duty_reg[0]));
    endproperty
    a_cmp_copy: assert property (p_cmp_copy) else $error("compare not copied");

    property p_cmp_hold;
        !ovf_evt |=> $stable(cmp_reg[1]);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed off overflow");

    property p_ovf_flag;
        s_overflow |=> ovf_reg ##0 (IRQ_OVF == oie_reg);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");

    property p_cap_take;
        (cap_edge[0] && !cap_flag_reg[0]) |=> cap_flag_reg[0] && (cap_reg[0] == $past(cnt_reg));
    endproperty
    a_cap_take: assert property (p_cap_take) else $error("capture not taken");

    property p_cap_block;
        (cap_flag_reg[1] && !cap_rd_clr[1]) |=> cap_flag_reg[1] && $stable(cap_reg[1]);
    endproperty
    a_cap_block: assert property (p_cap_block) else $error("capture overwrote");

    property p_reserved;
        (setup_ph && idx == `IDX_CAP_CSR) |=> rd_data_reg[7:6] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_cap_irq;
        (cap_flag_reg[0] && !cap_ie_reg[0] && !cap_flag_reg[1]) |-> !IRQ_CAP;
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("masked capture irq");

    property p_stop;
        !run_reg && !wr_cnt && !force_load |=> $stable(cnt_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped counter moved");

endmodule : pwm_reload_timer

// ==== pwm_reload_timer_pkg.sv ====
// types shared by the reload timer
package pwm_reload_timer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] clk_sel_t;
    typedef logic [6:0] presc_t;
    typedef logic [9:0] reg_idx_t;
endpackage : pwm_reload_timer_pkg

// ==== pwm_reload_timer_regs.svh ====
// register offsets, field positions, reset values and counts of the reload timer
`ifndef PWM_RELOAD_TIMER_REGS_SVH
`define PWM_RELOAD_TIMER_REGS_SVH

// register indices; byte address is four times the index
`define IDX_DUTY_CH3        10'h073
`define IDX_DUTY_CH2        10'h074
`define IDX_DUTY_CH1        10'h075
`define IDX_DUTY_CH0        10'h076
`define IDX_PWM_CTRL        10'h077
`define IDX_TIMER_CSR       10'h078
`define IDX_COUNTER         10'h079
`define IDX_RELOAD          10'h07A
`define IDX_CAP_CSR         10'h07B
`define IDX_CAP_CH1         10'h07C
`define IDX_CAP_CH2         10'h07D

// timer control/status fields
`define CSR_EXT_CLK_BIT     7
`define CSR_CC_MSB          6
`define CSR_CC_LSB          4
`define CSR_RUN_BIT         3
`define CSR_FORCE_BIT       2
`define CSR_OIE_BIT         1
`define CSR_OVF_BIT         0

// pwm control fields
`define PWM_OE_LSB          4
`define PWM_OP_LSB          0

// capture control/status fields
`define CAP_SEL_LSB         4
`define CAP_IE_LSB          2
`define CAP_FLAG_LSB        0

// values and counts
`define REG_RESET           8'h00
`define COUNT_MAX           8'hFF
`define PRESC_W             7
`endif

// ==== test_pwm_reload_timer.sv ====
// self-checking bench for the reload timer against a behavioural model
`timescale 1ns/10ps
`include "pwm_reload_timer_regs.svh"

module test_pwm_reload_timer;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq_ovf, irq_cap, ext_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    logic [1:0]  cap_req, cap_pin;
    logic        ext_req;
    logic [3:0]  pwm_out, pwm_oe, pin_level, op, oe;
    pwm_reload_timer_pkg::byte_t duty[4], cmp[4], cv[3], c;
    int          fails, compares, n;

    pwm_reload_timer dut_u (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_CLK_IN(ext_clk), .CAP_IN(cap_pin), .PWM_OUT(pwm_out),
        .PWM_OE(pwm_oe), .IRQ_OVF(irq_ovf), .IRQ_CAP(irq_cap)
    );

    pwm_pin_partner partner_u (
        .cap_req(cap_req), .cap_pin(cap_pin), .ext_clk_pin(ext_clk), .ext_req(ext_req),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pin_level(pin_level)
    );

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // request held from setup until pready is seen high
    task automatic apb(input logic wr, input pwm_reload_timer_pkg::reg_idx_t idx,
                       input pwm_reload_timer_pkg::byte_t wd);
        @(posedge clk_sys);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input pwm_reload_timer_pkg::reg_idx_t idx,
                      input pwm_reload_timer_pkg::byte_t d);
        apb(1'h1, idx, d);
    endtask : wr

    task automatic rdc(input pwm_reload_timer_pkg::reg_idx_t idx,
                       input pwm_reload_timer_pkg::byte_t exp, input logic e);
        apb(1'h0, idx, 8'h00);
        chk(rd, {24'h000000, exp});
        chk(32'(err), 32'(e));
    endtask : rdc

    function automatic logic [3:0] pwm_exp(input pwm_reload_timer_pkg::byte_t cv_in);
        logic [3:0] e;
        for (int i = 0; i < 4; i++) e[i] = ((cv_in <= cmp[i]) ^ op[i]) & oe[i];
        return e;
    endfunction : pwm_exp

    // one overflow loads compares, then new duties wait for the next one
    task automatic pwm_round();
        wr(`IDX_COUNTER, 8'hFF);
        wr(`IDX_TIMER_CSR, 8'h08);
        wr(`IDX_TIMER_CSR, 8'h00);
        cmp = duty;
        for (int i = 0; i < 4; i++) begin
            duty[i] = 8'($urandom);
            wr(`IDX_DUTY_CH0 - 10'(i), duty[i]);
        end
        for (int k = 0; k < 6; k++) begin
            c = 8'($urandom);
            {oe, op} = 8'($urandom);
            wr(`IDX_PWM_CTRL, {oe, op});
            wr(`IDX_COUNTER, c);
            repeat (3) @(posedge clk_sys);
            chk(32'(pin_level), 32'(pwm_exp(c)));
            chk(32'(pwm_oe), 32'(oe));
        end
    endtask : pwm_round

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end

    initial begin
        void'($urandom(32'h8BBD4231));
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        cap_req = 2'h2;
        ext_req = 1'h0;
        fails = 0;
        compares = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        wr(`IDX_CAP_CH1, 8'h55);
        for (int a = 'h73; a <= 'h7D; a++) rdc(10'(a), 8'h00, 1'h0);
        rdc(10'h072, 8'h00, 1'h1);
        rdc(10'h07E, 8'h00, 1'h1);
        wr(`IDX_CAP_CSR, 8'hFF);
        rdc(`IDX_CAP_CSR, 8'h3C, 1'h0);
        wr(`IDX_COUNTER, 8'h5A);
        rdc(`IDX_COUNTER, 8'h5A, 1'h0);
        wr(`IDX_RELOAD, 8'h00);
        for (int cc = 0; cc < 8; cc++) begin
            wr(`IDX_TIMER_CSR, 8'(8 | (cc << 4)));
            apb(1'h0, `IDX_COUNTER, 8'h00);
            c = rd[7:0];
            repeat (125) @(posedge clk_sys);
            apb(1'h0, `IDX_COUNTER, 8'h00);
            chk(rd, 32'(8'(c + (128 >> cc))));
        end
        // external clock: one count per rising edge
        wr(`IDX_TIMER_CSR, 8'h88);
        wr(`IDX_COUNTER, 8'h10);
        repeat (5) begin
            ext_req <= 1'h1;
            repeat (3) @(posedge clk_sys);
            ext_req <= 1'h0;
            repeat (3) @(posedge clk_sys);
        end
        rdc(`IDX_COUNTER, 8'h15, 1'h0);
        wr(`IDX_RELOAD, 8'hF0);
        wr(`IDX_COUNTER, 8'hFA);
        wr(`IDX_TIMER_CSR, 8'h0A);
        for (n = 0; n < 40 && irq_ovf !== 1'h1; n++) @(posedge clk_sys);
        chk(32'(irq_ovf), 32'h1);
        apb(1'h0, `IDX_COUNTER, 8'h00);
        chk(32'(rd[7:4]), 32'hF);
        rdc(`IDX_TIMER_CSR, 8'h0B, 1'h0);
        rdc(`IDX_TIMER_CSR, 8'h0A, 1'h0);
        chk(32'(irq_ovf), 32'h0);
        wr(`IDX_TIMER_CSR, 8'h04);
        rdc(`IDX_COUNTER, 8'hF0, 1'h0);
        rdc(`IDX_TIMER_CSR, 8'h00, 1'h0);
        wr(`IDX_RELOAD, 8'h00);
        for (int i = 0; i < 4; i++) begin
            duty[i] = 8'($urandom);
            wr(`IDX_DUTY_CH0 - 10'(i), duty[i]);
        end
        pwm_round();
        pwm_round();
        for (int i = 0; i < 3; i++) cv[i] = 8'($urandom);
        wr(`IDX_CAP_CSR, 8'h1C);
        wr(`IDX_COUNTER, cv[0]);
        cap_req[0] <= 1'h1;
        repeat (8) @(posedge clk_sys);
        chk(32'(irq_cap), 32'h1);
        rdc(`IDX_CAP_CSR, 8'h1D, 1'h0);
        wr(`IDX_COUNTER, cv[1]);
        cap_req[0] <= 1'h0;
        repeat (4) @(posedge clk_sys);
        cap_req[0] <= 1'h1;
        repeat (8) @(posedge clk_sys);
        rdc(`IDX_CAP_CH1, cv[0], 1'h0);
        rdc(`IDX_CAP_CSR, 8'h1C, 1'h0);
        cap_req[0] <= 1'h0;
        repeat (8) @(posedge clk_sys);
        rdc(`IDX_CAP_CSR, 8'h1C, 1'h0);
        wr(`IDX_COUNTER, cv[2]);
        cap_req[1] <= 1'h0;
        repeat (8) @(posedge clk_sys);
        rdc(`IDX_CAP_CSR, 8'h1E, 1'h0);
        wr(`IDX_CAP_CSR, 8'h10);
        repeat (2) @(posedge clk_sys);
        chk(32'(irq_cap), 32'h0);
        rdc(`IDX_CAP_CH2, cv[2], 1'h0);
        rdc(`IDX_CAP_CSR, 8'h10, 1'h0);
        summarize();
    end
endmodule : test_pwm_reload_timer
